// *** hdl/cmd_combiner_pkg.sv ***
package cmd_combiner_pkg;

    // Source selection codes shared by every combined function
    typedef enum logic [1:0] {
        SRC_TERMINAL = 2'h0,
        SRC_SERIAL   = 2'h1,
        SRC_AND      = 2'h2,
        SRC_OR       = 2'h3
    } src_sel_t;

    // Register byte offsets (word aligned)
    localparam logic [5:0] OFS_DIR_SRC    = 6'h00;
    localparam logic [5:0] OFS_SETUP_SRC  = 6'h04;
    localparam logic [5:0] OFS_PRESET_SRC = 6'h08;
    localparam logic [5:0] OFS_JOG_A      = 6'h0C;
    localparam logic [5:0] OFS_JOG_B      = 6'h10;
    localparam logic [5:0] OFS_PROFILE    = 6'h14;
    localparam logic [5:0] OFS_CTRL_WORD  = 6'h18;
    localparam logic [5:0] OFS_HIGH_LIMIT = 6'h1C;
    localparam logic [5:0] OFS_STATUS     = 6'h20;

    // Control word bit positions
    localparam int CW_REVERSE   = 0;
    localparam int CW_SETUP_LSB = 1;
    localparam int CW_SETUP_MSB = 2;
    localparam int CW_PRESET_LS = 3;
    localparam int CW_PRESET_MS = 4;
    localparam int CW_JOG_A     = 5;
    localparam int CW_JOG_B     = 6;

    // Status word field positions
    localparam int ST_REVERSE = 0;
    localparam int ST_SETUP   = 1;
    localparam int ST_PRESET  = 4;
    localparam int ST_JOG_A   = 6;
    localparam int ST_JOG_B   = 7;

    // Reset values; frequencies in 0.1 Hz steps
    localparam src_sel_t     RST_SRC        = SRC_OR;
    localparam logic         RST_PROFILE    = 1'b1;
    localparam logic [15:0]  RST_JOG        = 16'h0064;
    localparam logic [15:0]  RST_HIGH_LIMIT = 16'h01F4;
    localparam logic [15:0]  RST_CTRL_WORD  = 16'h0000;

    // Terminal inputs as one group
    typedef struct packed {
        logic       reverse;
        logic [1:0] setup;
        logic [1:0] preset;
    } term_t;

    // Combined commands presented to the drive
    typedef struct packed {
        logic        reverse_ccw;
        logic [2:0]  active_setup;
        logic [1:0]  preset_ref;
        logic        jog_active;
        logic [15:0] jog_freq;
    } drive_cmd_t;

endpackage

// *** hdl/drive_command_source_combiner.sv ***
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Direction source has four codes: terminal, serial, AND, OR; default OR.
// - Combined reverse request one means counter-clockwise, zero clockwise.
// - Setup source uses the same four codes, default OR.
// - Active setup is one plus twice msb plus lsb, giving one to four.
// - AND and OR combine bus and terminal setup bits bitwise.
// - Preset source, default OR; bus preset bits count only in native profile.
// - Two jog speeds up to high limit, default 10 Hz; bus selects only in fieldbus profile.
// - Telegram profile: 0 fieldbus layout, 1 native layout; default 1.
// - Serial-only source ignores the terminal and follows the telegram bits; for preset only in native profile, zero in fieldbus.
module drive_command_source_combiner
(
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         nrst,
    // Avalon-MM slave
    input  wire logic [5:0]                   address,
    input  wire logic                         read,
    input  wire logic                         write,
    input  wire logic [31:0]                  writedata,
    input  wire logic [3:0]                   byteenable,
    output logic      [31:0]                  readdata,
    output logic                              waitrequest,
    // Terminal inputs, asynchronous pins
    input  wire cmd_combiner_pkg::term_t      term_in,
    // Combined drive commands
    output cmd_combiner_pkg::drive_cmd_t      drive_cmd
);

    ////////////////////////////////////////////////////////////////////////
    // State of the block
    typedef struct packed {
        cmd_combiner_pkg::term_t      term_meta;
        cmd_combiner_pkg::term_t      term_sync;
        cmd_combiner_pkg::src_sel_t   dir_src;
        cmd_combiner_pkg::src_sel_t   setup_src;
        cmd_combiner_pkg::src_sel_t   preset_reference_source_sel;
        logic [15:0]                  bus_jog_speed_a;
        logic [15:0]                  bus_jog_speed_b;
        logic                         profile;
        logic [15:0]                  ctrl_word;
        logic [15:0]                  high_limit;
        logic                         wait_flag;
        logic [31:0]                  rdata;
        cmd_combiner_pkg::drive_cmd_t cmd;
    } state_t;

    localparam state_t RESET_STATE = '{
        term_meta:                   '0,
        term_sync:                   '0,
        dir_src:                     cmd_combiner_pkg::RST_SRC,
        setup_src:                   cmd_combiner_pkg::RST_SRC,
        preset_reference_source_sel: cmd_combiner_pkg::RST_SRC,
        bus_jog_speed_a:             cmd_combiner_pkg::RST_JOG,
        bus_jog_speed_b:             cmd_combiner_pkg::RST_JOG,
        profile:                     cmd_combiner_pkg::RST_PROFILE,
        ctrl_word:                   cmd_combiner_pkg::RST_CTRL_WORD,
        high_limit:                  cmd_combiner_pkg::RST_HIGH_LIMIT,
        wait_flag:                   1'b1,
        rdata:                       '0,
        cmd:                         '0
    };

    state_t st_reg;
    state_t st_next;

    ////////////////////////////////////////////////////////////////////////
    // Source combination of two bit vectors under one selection code
    function automatic logic [1:0] combine
    (
        input cmd_combiner_pkg::src_sel_t sel,
        input logic [1:0]                 term,
        input logic [1:0]                 ser
    );
        logic [1:0] res;
        case (sel)
            cmd_combiner_pkg::SRC_TERMINAL: res = term;
            cmd_combiner_pkg::SRC_SERIAL:   res = ser;
            cmd_combiner_pkg::SRC_AND:      res = term & ser;
            cmd_combiner_pkg::SRC_OR:       res = term | ser;
            default:                        res = term | ser;
        endcase
        return res;
    endfunction

    // Clamp a jog write to the output frequency high limit
    function automatic logic [15:0] clamp_jog
    (
        input logic [15:0] val,
        input logic [15:0] lim
    );
        return (val > lim) ? lim : val;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic [1:0]  rev_v;
        logic [1:0]  setup_v;
        logic [1:0]  preset_v;
        logic [1:0]  ser_preset;
        logic [31:0] rd;
        logic [15:0] wd;
        logic        req;
        logic        jog_a;
        logic        jog_b;
        rev_v      = '0;
        setup_v    = '0;
        preset_v   = '0;
        ser_preset = '0;
        rd         = '0;
        wd         = writedata[15:0];
        req        = read | write;
        jog_a      = 1'b0;
        jog_b      = 1'b0;
        st_next    = st_reg;

        // Two-stage synchroniser on terminal pins
        st_next.term_meta = term_in;
        st_next.term_sync = st_reg.term_meta;

        // Bus handshake: one wait cycle, then one ready cycle
        st_next.wait_flag = !(req && st_reg.wait_flag);

        // Read data is captured while waitrequest is still high
        case (address)
            cmd_combiner_pkg::OFS_DIR_SRC:    rd[1:0]  = st_reg.dir_src;
            cmd_combiner_pkg::OFS_SETUP_SRC:  rd[1:0]  = st_reg.setup_src;
            cmd_combiner_pkg::OFS_PRESET_SRC: rd[1:0]  = st_reg.preset_reference_source_sel;
            cmd_combiner_pkg::OFS_JOG_A:      rd[15:0] = st_reg.bus_jog_speed_a;
            cmd_combiner_pkg::OFS_JOG_B:      rd[15:0] = st_reg.bus_jog_speed_b;
            cmd_combiner_pkg::OFS_PROFILE:    rd[0]    = st_reg.profile;
            cmd_combiner_pkg::OFS_CTRL_WORD:  rd[15:0] = st_reg.ctrl_word;
            cmd_combiner_pkg::OFS_HIGH_LIMIT: rd[15:0] = st_reg.high_limit;
            cmd_combiner_pkg::OFS_STATUS:
            begin
                rd[cmd_combiner_pkg::ST_REVERSE]                     = st_reg.cmd.reverse_ccw;
                rd[cmd_combiner_pkg::ST_SETUP +: 3]                  = st_reg.cmd.active_setup;
                rd[cmd_combiner_pkg::ST_PRESET +: 2]                 = st_reg.cmd.preset_ref;
                rd[cmd_combiner_pkg::ST_JOG_A]                       = st_reg.cmd.jog_active
                    && !st_reg.ctrl_word[cmd_combiner_pkg::CW_JOG_B];
                rd[cmd_combiner_pkg::ST_JOG_B]                       = st_reg.cmd.jog_active
                    && st_reg.ctrl_word[cmd_combiner_pkg::CW_JOG_B];
            end
            default:                          rd = '0; // Unmapped reads zero
        endcase
        if (read && st_reg.wait_flag)
            st_next.rdata = rd;

        // Writes take effect on the edge where waitrequest is low
        if (write && !st_reg.wait_flag && byteenable[0])
        begin
            case (address)
                cmd_combiner_pkg::OFS_DIR_SRC:
                    st_next.dir_src = cmd_combiner_pkg::src_sel_t'(writedata[1:0]);
                cmd_combiner_pkg::OFS_SETUP_SRC:
                    st_next.setup_src = cmd_combiner_pkg::src_sel_t'(writedata[1:0]);
                cmd_combiner_pkg::OFS_PRESET_SRC:
                    st_next.preset_reference_source_sel =
                        cmd_combiner_pkg::src_sel_t'(writedata[1:0]);
                cmd_combiner_pkg::OFS_PROFILE:
                    st_next.profile = writedata[0];
                default:
                    st_next.profile = st_reg.profile;
            endcase
        end
        // 16-bit registers need both low byte lanes; a partial write is ignored
        if (write && !st_reg.wait_flag && (byteenable[1:0] == 2'h3))
        begin
            case (address)
                cmd_combiner_pkg::OFS_JOG_A:
                    st_next.bus_jog_speed_a = clamp_jog(wd, st_reg.high_limit);
                cmd_combiner_pkg::OFS_JOG_B:
                    st_next.bus_jog_speed_b = clamp_jog(wd, st_reg.high_limit);
                cmd_combiner_pkg::OFS_CTRL_WORD:
                    st_next.ctrl_word = wd;
                cmd_combiner_pkg::OFS_HIGH_LIMIT:
                begin
                    // Lowering the limit pulls stored jog speeds down with it
                    st_next.high_limit      = wd;
                    st_next.bus_jog_speed_a = clamp_jog(st_reg.bus_jog_speed_a, wd);
                    st_next.bus_jog_speed_b = clamp_jog(st_reg.bus_jog_speed_b, wd);
                end
                default:
                    st_next.high_limit = st_reg.high_limit;
            endcase
        end

        // Combination, re-evaluated every cycle from registered inputs
        rev_v = combine(st_reg.dir_src,
                        {1'b0, st_reg.term_sync.reverse},
                        {1'b0, st_reg.ctrl_word[cmd_combiner_pkg::CW_REVERSE]});
        st_next.cmd.reverse_ccw = rev_v[0];

        setup_v = combine(st_reg.setup_src, st_reg.term_sync.setup,
                          {st_reg.ctrl_word[cmd_combiner_pkg::CW_SETUP_MSB],
                           st_reg.ctrl_word[cmd_combiner_pkg::CW_SETUP_LSB]});
        st_next.cmd.active_setup = 3'h1 + {1'b0, setup_v};

        // Bus preset bits count as zero outside the native profile
        if (st_reg.profile)
            ser_preset = {st_reg.ctrl_word[cmd_combiner_pkg::CW_PRESET_MS],
                          st_reg.ctrl_word[cmd_combiner_pkg::CW_PRESET_LS]};
        preset_v = combine(st_reg.preset_reference_source_sel,
                           st_reg.term_sync.preset, ser_preset);
        st_next.cmd.preset_ref = preset_v;

        // Jog via bus only in fieldbus profile; jog b wins when both set
        jog_a = !st_reg.profile && st_reg.ctrl_word[cmd_combiner_pkg::CW_JOG_A];
        jog_b = !st_reg.profile && st_reg.ctrl_word[cmd_combiner_pkg::CW_JOG_B];
        st_next.cmd.jog_active = jog_a | jog_b;
        st_next.cmd.jog_freq   = jog_b ? st_reg.bus_jog_speed_b :
                                 (jog_a ? st_reg.bus_jog_speed_a : 16'h0000);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, synchronous reset
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            st_reg <= RESET_STATE;
        else
            st_reg <= st_next;
    end

    // Outputs straight from flops
    assign readdata    = st_reg.rdata;
    assign waitrequest = st_reg.wait_flag;
    assign drive_cmd   = st_reg.cmd;

endmodule

// *** verif/cmd_combiner_props.sv ***
`timescale 1ns/1ps
module cmd_combiner_props
(
    // Clock, reset and bus
    input wire logic                         mclk,
    input wire logic                         nrst,
    input wire logic [5:0]                   address,
    input wire logic                         read,
    input wire logic                         write,
    input wire logic [31:0]                  writedata,
    input wire logic [3:0]                   byteenable,
    input wire logic                         waitrequest,
    // Pins and commands
    input wire cmd_combiner_pkg::term_t      term_in,
    input wire cmd_combiner_pkg::drive_cmd_t drive_cmd
);
    logic [1:0] src_reg [3];
    logic       prof_reg;
    logic [4:0] cw_reg;
    logic       taken;
    assign taken = write && !waitrequest && byteenable[0];
    // Shadow settings, fed only by writes the slave accepted
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            src_reg  <= '{2'h3, 2'h3, 2'h3};
            prof_reg <= 1'b1;
            cw_reg   <= 5'h00;
        end
        else if (taken && address < 6'h0C)
            src_reg[address[3:2]] <= writedata[1:0];
        else if (taken && address == 6'h14)
            prof_reg <= writedata[0];
        else if (taken && address == 6'h18 && byteenable[1])
            cw_reg <= writedata[4:0];
    end
    function automatic logic [1:0] comb(input logic [1:0] s, input logic [1:0] t, input logic [1:0] b);
        return s == 2'h0 ? t : s == 2'h1 ? b : s == 2'h2 ? (t & b) : (t | b);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Pins held still long enough to pass the synchronizer
    sequence steady_s;
        $past(nrst, 3) && $past(nrst, 2) && $past(nrst) && $past(term_in, 3) == term_in
            && $past(term_in, 2) == term_in && $past(term_in) == term_in;
    endsequence
    sequence req_s;
        (read || write) && waitrequest;
    endsequence
    sequence ack_s;
        !waitrequest ##1 waitrequest;
    endsequence
    chk_bus_ack: assert property (req_s |=> ack_s)
        else $error("bus answer not one cycle wide");
    chk_bus_idle: assert property (!(read || write) && waitrequest |=> waitrequest)
        else $error("bus answered without request");
    chk_dir_comb: assert property (steady_s |-> {1'b0, drive_cmd.reverse_ccw} ==
        comb($past(src_reg[0]), {1'b0, term_in.reverse}, {1'b0, $past(cw_reg[0])}))
        else $error("direction combination wrong");
    chk_setup_comb: assert property (steady_s |-> drive_cmd.active_setup ==
        3'h1 + {1'b0, comb($past(src_reg[1]), term_in.setup, $past(cw_reg[2:1]))})
        else $error("setup number wrong");
    chk_preset_comb: assert property (steady_s |-> drive_cmd.preset_ref ==
        comb($past(src_reg[2]), term_in.preset, $past(prof_reg) ? $past(cw_reg[4:3]) : 2'h0))
        else $error("preset selection wrong");
    chk_setup_range: assert property ($past(nrst) |-> drive_cmd.active_setup inside {[3'h1:3'h4]})
        else $error("setup number out of range");
    chk_jog_native: assert property ($past(prof_reg) |-> !drive_cmd.jog_active)
        else $error("jog taken in native layout");
    chk_jog_idle: assert property (!drive_cmd.jog_active |-> drive_cmd.jog_freq == 16'h0000)
        else $error("jog speed without jog");
endmodule
bind drive_command_source_combiner cmd_combiner_props cmd_combiner_props_inst (.mclk(mclk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .waitrequest(waitrequest), .term_in(term_in), .drive_cmd(drive_cmd));

// *** verif/ctrl_word_master.sv ***
`timescale 1ns/1ps
module ctrl_word_master
(
    // Clock
    input  wire logic        mclk,
    // Avalon-MM master side
    output logic [5:0]       address,
    output logic             read,
    output logic             write,
    output logic [31:0]      writedata,
    output logic [3:0]       byteenable,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest
);
    // Idle bus from time zero
    initial
    begin
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
    end
    // Request stands until the stall ends; no fixed latency assumed
    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
                        output logic [31:0] q);
        @(posedge mclk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= be;
        do
            @(posedge mclk);
        while (waitrequest);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        writedata <= ~d; // Released data never keeps its last value
    endtask
    // Telegram bits placed at the control word positions
    task automatic telegram(input logic [6:0] bits);
        logic [31:0] q;
        xfer(1'b1, 6'h18, {25'h0, bits}, 4'h3, q);
    endtask
endmodule

// *** verif/drive_command_source_combiner_bench.sv ***
`timescale 1ns/1ps
module drive_command_source_combiner_bench;
    logic                         mclk;
    logic                         nrst;
    logic [5:0]                   address;
    logic                         read;
    logic                         write;
    logic [31:0]                  writedata;
    logic [3:0]                   byteenable;
    logic [31:0]                  readdata;
    logic                         waitrequest;
    cmd_combiner_pkg::term_t      term_in;
    cmd_combiner_pkg::drive_cmd_t drive_cmd;
    logic [31:0]                  exp_q [$];
    logic [31:0]                  rd;
    int                           num_errors = 0;
    int                           num_checks = 0;
    int                           seed = 77;
    drive_command_source_combiner drive_command_source_combiner_inst (.mclk(mclk), .nrst(nrst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .term_in(term_in), .drive_cmd(drive_cmd));
    ctrl_word_master ctrl_word_master_inst (.mclk(mclk), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));
    // 25 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    function automatic logic [1:0] comb(input logic [1:0] s, input logic [1:0] t, input logic [1:0] b);
        return s == 2'h0 ? t : s == 2'h1 ? b : s == 2'h2 ? (t & b) : (t | b);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Expectation noted before the read is issued
    task automatic rd_exp(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        ctrl_word_master_inst.xfer(1'b0, a, 32'h0, 4'hF, rd);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        ctrl_word_master_inst.xfer(1'b1, a, d, 4'hF, rd);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Each completed read takes the oldest note off the queue
    always @(posedge mclk)
    begin
        if (read && !waitrequest && exp_q.size() > 0)
            check(readdata, exp_q.pop_front());
    end
    // Hang guard, far beyond the roughly 800 cycles needed
    initial
    begin
        repeat (6000) @(posedge mclk);
        num_errors++;
        final_report();
    end
    // Main sequence
    initial
    begin
        logic [1:0] ds, ss, ps, rv, st;
        logic [6:0] cw;
        logic [15:0] jv;
        logic pf;
        logic [37:0] tab [10];
        cmd_combiner_pkg::term_t tv;
        tab = '{{6'h00, 32'h3}, {6'h04, 32'h3}, {6'h08, 32'h3}, {6'h0C, 32'h64}, {6'h10, 32'h64},
                {6'h14, 32'h1}, {6'h18, 32'h0}, {6'h1C, 32'h1F4}, {6'h20, 32'h2}, {6'h24, 32'h0}};
        nrst = 1'b0;
        term_in = '0;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        foreach (tab[i]) rd_exp(tab[i][37:32], tab[i][31:0]);
        // Every direction and setup source code against random preset codes, pins, bits and layouts
        for (int i = 0; i < 32; i++)
        begin
            ds = 2'(i);
            ss = 2'(i >> 2);
            ps = 2'($random(seed));
            pf = 1'($random(seed));
            cw = 7'($random(seed)) & 7'h1F;
            tv = 5'($random(seed));
            wr(6'h00, {30'h0, ds});
            wr(6'h04, {30'h0, ss});
            wr(6'h08, {30'h0, ps});
            wr(6'h14, {31'h0, pf});
            ctrl_word_master_inst.telegram(cw);
            term_in <= tv;
            repeat (4) @(posedge mclk);
            rv = comb(ds, {1'b0, tv.reverse}, {1'b0, cw[0]});
            st = comb(ss, tv.setup, cw[2:1]);
            ps = comb(ps, tv.preset, pf ? cw[4:3] : 2'h0);
            rd_exp(6'h20, {26'h0, ps, 3'h1 + {1'b0, st}, rv[0]});
        end
        // Jog speeds: fieldbus layout selects, native layout ignores
        jv = 16'($random(seed)) % 16'h01F4;
        wr(6'h14, 32'h0);
        wr(6'h08, 32'h0);
        wr(6'h0C, {16'h0, jv});
        ctrl_word_master_inst.telegram(7'h20);
        repeat (2) @(posedge mclk);
        check({16'h0, drive_cmd.jog_freq}, {16'h0, jv});
        ctrl_word_master_inst.telegram(7'h40);
        repeat (2) @(posedge mclk);
        check({16'h0, drive_cmd.jog_freq}, 32'h64);
        // Status shows jog b; terminal-only preset, no bus direction or setup bits
        rv = comb(ds, {1'b0, tv.reverse}, 2'h0);
        st = comb(ss, tv.setup, 2'h0);
        rd_exp(6'h20, {24'h0, 2'h2, tv.preset, 3'h1 + {1'b0, st}, rv[0]});
        wr(6'h14, 32'h1);
        repeat (2) @(posedge mclk);
        check({31'h0, drive_cmd.jog_active}, 32'h0);
        // Partial lanes refused, oversize jog clamped, then reset mid-run
        ctrl_word_master_inst.xfer(1'b1, 6'h18, 32'h7F, 4'h1, rd);
        rd_exp(6'h18, 32'h40);
        wr(6'h10, 32'hFFFF);
        rd_exp(6'h10, 32'h1F4);
        // Lowering the limit pulls both stored jog speeds down
        wr(6'h1C, 32'h50);
        rd_exp(6'h1C, 32'h50);
        rd_exp(6'h10, 32'h50);
        rd_exp(6'h0C, {16'h0, ((jv > 16'h0050) ? 16'h0050 : jv)});
        // Profile write without the low lane is refused
        ctrl_word_master_inst.xfer(1'b1, 6'h14, 32'h0, 4'h2, rd);
        rd_exp(6'h14, 32'h1);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd_exp(6'h00, 32'h3);
        repeat (3) @(posedge mclk);
        final_report();
    end
endmodule
